// ===== verilog/asfc_defines.svh
`ifndef ASFC_DEFINES_SVH
`define ASFC_DEFINES_SVH
// Register port geometry
`define ASFC_ADDR_W 8
`define ASFC_REG_W 24
// Register offsets
`define ASFC_OFF_DATA 8'h04
`define ASFC_OFF_CTRL 8'h3A
`define ASFC_OFF_FSTAT 8'h3B
`define ASFC_OFF_FDATA 8'h3C
`define ASFC_OFF_ISTAT 8'h3D
`define ASFC_OFF_ICLR 8'h3E
// Control register reset value and writable bits (23:20 stay zero)
`define ASFC_CTRL_RESET 24'h040200
`define ASFC_CTRL_WMASK 24'h0FFFFF
// Control field positions
`define ASFC_MODE_HI 17
`define ASFC_MODE_LO 16
`define ASFC_EN_HI 14
`define ASFC_EN_LO 8
`define ASFC_THR_HI 7
`define ASFC_THR_LO 0
// Event bit positions, shared by status, clear and enable field
`define ASFC_EV_DRAIN 0
`define ASFC_EV_WMARK 1
`define ASFC_EV_OVR 2
`define ASFC_EV_LOW 3
`define ASFC_EV_HIGH 4
`define ASFC_EV_FETCH 5
`define ASFC_EV_STORE 6
`define ASFC_EV_N 7
// Sizing defaults
`define ASFC_DEPTH 256
`define ASFC_DATA_W 16
`define ASFC_THR_ZERO_N 256
`define ASFC_LOW_LEVEL 64
`define ASFC_HIGH_LEVEL 192
`endif

// ===== verilog/asfc_pkg.sv
`default_nettype none
package asfc_pkg;
    // Operating mode, one-hot
    typedef enum logic [2:0] {
        ASFC_MODE_OFF = 3'h1,
        ASFC_MODE_FILL = 3'h2,
        ASFC_MODE_STREAM = 3'h4
    } asfc_mode_t;

    // Two-bit mode field to mode; both upper codes stream
    function automatic asfc_mode_t asfc_decode_mode(input logic [1:0] f);
        case (f)
            2'h0: asfc_decode_mode = ASFC_MODE_OFF;
            2'h1: asfc_decode_mode = ASFC_MODE_FILL;
            default: asfc_decode_mode = ASFC_MODE_STREAM;
        endcase
    endfunction : asfc_decode_mode
endpackage : asfc_pkg
`default_nettype wire

// ===== verilog/asfc_sample_mem.sv
`default_nettype none
module asfc_sample_mem #(
    parameter int DEPTH = 256,
    parameter int WIDTH = 16
) (
    input wire logic mclk,
    input wire logic wr_en,
    input wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    // Sample storage; no reset, contents are only valid below the count
    logic [WIDTH-1:0] mem_q [DEPTH];

    // Head of queue is always visible, so a pop needs no extra cycle
    assign rd_data = mem_q[rd_addr];

    // Single write port
    always_ff @(posedge mclk) begin
        if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
    end
endmodule : asfc_sample_mem
`default_nettype wire

// ===== verilog/asfc_sticky_flags.sv
`default_nettype none
module asfc_sticky_flags #(
    parameter int N = 7
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [N-1:0] set,
    input wire logic [N-1:0] clr,
    output logic [N-1:0] flags_q
);
    // Set wins over clear, so an event in the clearing cycle survives
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            flags_q <= '0;
        end else begin
            flags_q <= (flags_q & ~clr) | set;
        end
    end
endmodule : asfc_sticky_flags
`default_nettype wire

// ===== verilog/asfc_fifo_ctrl.sv
`include "asfc_defines.svh"
`default_nettype none
module asfc_fifo_ctrl
    import asfc_pkg::*;
#(
    parameter int DEPTH = `ASFC_DEPTH,
    parameter int DATA_W = `ASFC_DATA_W,
    parameter int LOW_LEVEL = `ASFC_LOW_LEVEL,
    parameter int HIGH_LEVEL = `ASFC_HIGH_LEVEL
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic conv_valid,
    input wire logic [DATA_W-1:0] conv_data,
    input wire logic [`ASFC_ADDR_W-1:0] reg_addr,
    input wire logic [`ASFC_REG_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`ASFC_REG_W-1:0] reg_rdata_q,
    output logic irq
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = PW + 1;
    localparam int NEV = `ASFC_EV_N;

    // Refuse sizes the counters and threshold decode cannot serve
    if (DEPTH < `ASFC_THR_ZERO_N || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_bad_depth
        $error("DEPTH must be a power of two, at least 256");
    end
    if (DATA_W < 1 || DATA_W > `ASFC_REG_W) begin : g_bad_width
        $error("DATA_W must lie between 1 and 24");
    end
    if (LOW_LEVEL < 1 || HIGH_LEVEL > DEPTH || LOW_LEVEL >= HIGH_LEVEL)
    begin : g_bad_levels
        $error("Levels must satisfy 1 <= LOW < HIGH <= DEPTH");
    end

    localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
    localparam logic [CW-1:0] LOW_C = CW'(LOW_LEVEL);
    localparam logic [CW-1:0] HIGH_C = CW'(HIGH_LEVEL);
    localparam logic [CW-1:0] ZERO_N = CW'(`ASFC_THR_ZERO_N);

    // Control register and its next value
    logic [`ASFC_REG_W-1:0] ctrl_q;
    logic [`ASFC_REG_W-1:0] ctrl_d;
    // Occupancy, pointers and fill-mode hold
    logic [CW-1:0] count_q;
    logic [CW-1:0] count_d;
    logic [PW-1:0] wr_ptr_q;
    logic [PW-1:0] rd_ptr_q;
    logic hold_q;
    logic hold_d;
    // Latest conversion for the FIFO-off data register
    logic [DATA_W-1:0] data_q;
    // Sticky interrupt status and its enable field
    logic [NEV-1:0] irq_stat_q;
    logic [NEV-1:0] irq_en;
    logic [NEV-1:0] ev_set;
    logic [NEV-1:0] irq_clr;
    // Memory head and read mux
    logic [DATA_W-1:0] head_data;
    logic [`ASFC_REG_W-1:0] rd_mux;

    // Address decode
    wire hit_ctrl = (reg_addr == `ASFC_OFF_CTRL);
    wire hit_fdata = (reg_addr == `ASFC_OFF_FDATA);
    wire hit_iclr = (reg_addr == `ASFC_OFF_ICLR);
    wire wr_ctrl = reg_wr && hit_ctrl;
    wire pop_req = reg_rd && hit_fdata;

    // Mode decode from the two-bit field
    wire asfc_mode_t mode =
        asfc_decode_mode(ctrl_q[`ASFC_MODE_HI:`ASFC_MODE_LO]);
    wire mode_off = (mode == ASFC_MODE_OFF);
    wire mode_fill = (mode == ASFC_MODE_FILL);
    wire mode_stream = (mode == ASFC_MODE_STREAM);

    // Threshold code 0 stands for a whole 256-entry target
    wire [7:0] thr_code = ctrl_q[`ASFC_THR_HI:`ASFC_THR_LO];
    // Code 1 is still served literally; its watermark fires each time the count rises from 0 to 1
    wire [CW-1:0] thr_n =
        (thr_code == 8'h00) ? ZERO_N : CW'(thr_code);

    // Enables sit at bits 14:8 in event order
    assign irq_en = ctrl_q[`ASFC_EN_HI:`ASFC_EN_LO];

    // Occupancy conditions
    wire fifo_empty = (count_q == '0);
    wire fifo_full = (count_q == DEPTH_C);
    // Fill mode treats the FIFO as full from target until drained
    wire fill_block = hold_q || (count_q >= thr_n);

    // A conversion is stored in stream mode, and in fill mode unless blocked; never while off
    wire accept = conv_valid &&
        (mode_stream || (mode_fill && !fill_block));
    // Stream mode overwrites: the oldest entry leaves with no read
    wire drop_old = conv_valid && mode_stream && fifo_full;
    // A fill-mode conversion that finds the FIFO held is lost
    wire fill_lost = conv_valid && mode_fill && fill_block;
    // A conversion in the same cycle wins the port; the read fails
    wire pop_ok = pop_req && !fifo_empty && !conv_valid && !mode_off;
    wire pop_fail = pop_req && !pop_ok;
    wire rd_adv = pop_ok || drop_old;

    // Next occupancy; turning the FIFO off flushes it
    always_comb begin
        count_d = count_q;
        if (mode_off) begin
            count_d = '0;
        end else begin
            count_d = count_q + CW'(accept) - CW'(rd_adv);
        end
    end

    // Hold is taken at the target and let go only once emptied
    always_comb begin
        hold_d = hold_q;
        if (mode_off || count_d == '0) begin
            hold_d = 1'b0;
        end else if (mode_fill && accept && count_d == thr_n) begin
            hold_d = 1'b1;
        end
    end

    // Event pulses into the sticky status
    always_comb begin
        ev_set = '0;
        ev_set[`ASFC_EV_DRAIN] = !fifo_empty && (count_d == '0);
        ev_set[`ASFC_EV_WMARK] = accept && (count_d == thr_n) &&
            (count_q != thr_n);
        ev_set[`ASFC_EV_OVR] = drop_old || fill_lost;
        ev_set[`ASFC_EV_LOW] = (count_q >= LOW_C) && (count_d < LOW_C);
        ev_set[`ASFC_EV_HIGH] = (count_q < HIGH_C) && (count_d >= HIGH_C);
        ev_set[`ASFC_EV_FETCH] = pop_fail;
        ev_set[`ASFC_EV_STORE] = fill_lost;
    end

    // Write-one-to-clear through the clear register
    assign irq_clr = (reg_wr && hit_iclr) ? reg_wdata[NEV-1:0] : '0;

    // Control register; reserved bit 15 is plain storage
    assign ctrl_d = wr_ctrl ?
        (reg_wdata & `ASFC_CTRL_WMASK) : ctrl_q;

    // Control register update; enable field resets to 0x02
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ctrl_q <= `ASFC_CTRL_RESET;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // Occupancy, hold and pointers
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            count_q <= '0;
            hold_q <= 1'b0;
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else if (mode_off) begin
            // Flush so a later mode starts from an empty FIFO
            count_q <= '0;
            hold_q <= 1'b0;
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else begin
            count_q <= count_d;
            hold_q <= hold_d;
            wr_ptr_q <= wr_ptr_q + PW'(accept);
            rd_ptr_q <= rd_ptr_q + PW'(rd_adv);
        end
    end

    // FIFO-off data register keeps the newest conversion
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            data_q <= '0;
        end else if (conv_valid && mode_off) begin
            data_q <= conv_data;
        end
    end

    // Sample storage
    asfc_sample_mem #(
        .DEPTH(DEPTH),
        .WIDTH(DATA_W)
    ) u_mem (
        .mclk(mclk),
        .wr_en(accept),
        .wr_addr(wr_ptr_q),
        .wr_data(conv_data),
        .rd_addr(rd_ptr_q),
        .rd_data(head_data)
    );

    // Sticky status for all seven events
    asfc_sticky_flags #(
        .N(NEV)
    ) u_flags (
        .mclk(mclk),
        .rst_n(rst_n),
        .set(ev_set),
        .clr(irq_clr),
        .flags_q(irq_stat_q)
    );

    // One level output, each flag gated by its own enable bit
    wire [NEV-1:0] irq_gated = irq_stat_q & irq_en;
    assign irq = |irq_gated;

    // Read mux; unmapped and write-only addresses read as zero
    always_comb begin
        rd_mux = '0;
        case (reg_addr)
            `ASFC_OFF_CTRL: rd_mux = ctrl_q;
            `ASFC_OFF_DATA: rd_mux = `ASFC_REG_W'(data_q);
            `ASFC_OFF_FSTAT: rd_mux = `ASFC_REG_W'({hold_q, fifo_full,
                fifo_empty, count_q});
            `ASFC_OFF_FDATA: rd_mux = fifo_empty ? '0 :
                `ASFC_REG_W'(head_data);
            `ASFC_OFF_ISTAT: rd_mux = `ASFC_REG_W'(irq_stat_q);
            default: rd_mux = '0;
        endcase
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            reg_rdata_q <= '0;
        end else if (reg_rd) begin
            reg_rdata_q <= rd_mux;
        end else begin
            reg_rdata_q <= '0;
        end
    end

    // Checks and coverage
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    a_mode_off_flush: assert property (
        mode_off |=> (count_q == '0) && !hold_q)
        else $error("FIFO not flushed while off");

    a_fill_blocks: assert property (
        (mode_fill && fill_block && conv_valid && !wr_ctrl)
        |=> (count_q <= $past(count_q)) && irq_stat_q[`ASFC_EV_STORE])
        else $error("Fill mode stored past its target");

    a_fill_hold_target: assert property (
        (mode_fill && accept && count_d == thr_n && !wr_ctrl)
        |=> hold_q)
        else $error("Fill target did not hold the FIFO");

    a_stream_stays_full: assert property (
        (mode_stream && conv_valid && fifo_full && !wr_ctrl)
        |=> fifo_full && (rd_ptr_q == $past(rd_ptr_q) + PW'(1)))
        else $error("Stream mode did not drop the oldest");

    a_overrun_sticky: assert property (
        (drop_old && !wr_ctrl)
        |=> irq_stat_q[`ASFC_EV_OVR] ##1
        (irq_stat_q[`ASFC_EV_OVR] || $past(irq_clr[`ASFC_EV_OVR])))
        else $error("Overrun flag missing after a drop");

    a_store_irq: assert property (
        (ev_set[`ASFC_EV_STORE] && irq_en[`ASFC_EV_STORE] && !wr_ctrl)
        |=> irq)
        else $error("Store error did not interrupt");

    a_fetch_irq: assert property (
        (pop_fail && irq_en[`ASFC_EV_FETCH] && !wr_ctrl) |=> irq)
        else $error("Fetch error did not interrupt");

    a_high_irq: assert property (
        (ev_set[`ASFC_EV_HIGH] && irq_en[`ASFC_EV_HIGH] && !wr_ctrl)
        |=> irq)
        else $error("Upper level did not interrupt");

    a_low_irq: assert property (
        (ev_set[`ASFC_EV_LOW] && irq_en[`ASFC_EV_LOW] && !wr_ctrl)
        |=> irq)
        else $error("Lower level did not interrupt");

    a_overrun_irq: assert property (
        (drop_old && irq_en[`ASFC_EV_OVR] && !wr_ctrl) |=> irq)
        else $error("Overrun did not interrupt");

    a_enable_reset: assert property (
        $rose(rst_n) |-> (irq_en == 7'h02) && (ctrl_q[15] == 1'b0))
        else $error("Enable field reset value wrong");

    a_drain_irq: assert property (
        (ev_set[`ASFC_EV_DRAIN] && irq_en[`ASFC_EV_DRAIN] && !wr_ctrl)
        |=> irq && irq_stat_q[`ASFC_EV_DRAIN])
        else $error("Drained flag and interrupt not together");

    a_thr_decode: assert property (
        (mode_fill && thr_code == 8'h00 && count_q == CW'(255) &&
         accept && !hold_q && !wr_ctrl)
        |=> hold_q && (count_q == ZERO_N))
        else $error("Code zero did not mean 256");

    a_irq_quiet: assert property (
        ((irq_stat_q & irq_en) == '0) |-> !irq)
        else $error("Interrupt high with no enabled flag");

    // A granted read takes exactly one entry; nothing else moves then
    a_pop_one: assert property (
        (pop_ok && !wr_ctrl)
        |=> count_q == $past(count_q) - CW'(1))
        else $error("Granted read did not remove one entry");

    a_off_data: assert property (
        (mode_off && conv_valid)
        |=> (data_q == $past(conv_data)) && (count_q == '0))
        else $error("Off mode lost the newest conversion");

    c_stream_drop: cover property (drop_old);
    c_fill_lost: cover property (fill_lost ##[1:300] ev_set[`ASFC_EV_DRAIN]);
    c_wmark_event: cover property (ev_set[`ASFC_EV_WMARK] ##1 irq);
    c_read_refused: cover property (pop_req && conv_valid && !fifo_empty);
    c_fill_full_hold: cover property (
        mode_fill && (thr_code == 8'h00) && ev_set[`ASFC_EV_WMARK]);
endmodule : asfc_fifo_ctrl
`default_nettype wire

// ===== verif/asfc_conv_src.sv
`default_nettype none
// Stand-in for the converter core that feeds samples to the block
module asfc_conv_src (
    input wire logic mclk,
    output logic conv_valid,
    output logic [15:0] conv_data
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle at time zero; the data line carries junk between samples
    initial begin
        conv_valid = 1'b0;
        conv_data = 16'h5A5A;
    end

    // One-cycle sample pulse; data inverted afterwards so a stale
    // value can never pass for a fresh sample
    task automatic push(input logic [15:0] d);
        @(posedge mclk);
        conv_valid <= 1'b1;
        conv_data <= d;
        @(posedge mclk);
        conv_valid <= 1'b0;
        conv_data <= ~d;
    endtask : push
endmodule : asfc_conv_src
`default_nettype wire

// ===== verif/tb.sv
`include "asfc_defines.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic mclk; // 250 MHz system clock
    logic rst_n; // Synchronous reset, active low
    logic conv_valid; // Sample strobe from the source model
    logic [15:0] conv_data; // Sample value from the source model
    logic [7:0] reg_addr; // Register address
    logic [23:0] reg_wdata; // Register write data
    logic reg_wr; // Write strobe
    logic reg_rd; // Read strobe
    logic [23:0] reg_rdata_q; // Read data, one cycle after strobe
    logic irq; // Level interrupt
    int num_errors; // Mismatches seen
    int n_compared; // Comparisons made
    int i; // Loop index

    asfc_fifo_ctrl uut (
        .mclk(mclk), .rst_n(rst_n), .conv_valid(conv_valid),
        .conv_data(conv_data), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_q(reg_rdata_q), .irq(irq)
    );
    asfc_conv_src src (
        .mclk(mclk), .conv_valid(conv_valid), .conv_data(conv_data)
    );

    // Free-running clock, 4 ns period
    initial mclk = 1'b0;
    always #2 mclk = ~mclk;

    // Compare and count; four-state equality so unknowns fail
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got,
                exp);
        end
    endtask : chk

    // One-cycle write strobe, launched just after an edge
    task automatic wr(input logic [7:0] a, input logic [23:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr

    // One-cycle read; data sampled in the single cycle it stands
    task automatic rdc(input logic [7:0] a, input logic [23:0] m,
        input logic [23:0] exp);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata_q & m, exp);
    endtask : rdc

    // Interrupt level check, let the write edge settle first
    task automatic irq_is(input logic exp);
        #1 chk({23'h000000, irq}, {23'h000000, exp});
    endtask : irq_is

    // Single exit point of the run
    task automatic stop_test;
        $display("Compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : stop_test

    // Watchdog: a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge mclk);
        num_errors++;
        stop_test();
    end

    // Main sequence
    initial begin
        rst_n = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 24'h000000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        // Reset values, unmapped address
        rdc(`ASFC_OFF_CTRL, 24'hFFFFFF, 24'h040200);
        rdc(`ASFC_OFF_ISTAT, 24'hFFFFFF, 24'h000000);
        irq_is(1'b0);
        rdc(8'h00, 24'hFFFFFF, 24'h000000);
        // Top nibble is read-only; software keeps bit 15 at zero
        wr(`ASFC_OFF_CTRL, 24'hF17F05);
        rdc(`ASFC_OFF_CTRL, 24'hFFFFFF, 24'h017F05);
        // Streaming, code 11, threshold code zero means a full buffer
        wr(`ASFC_OFF_CTRL, 24'h030000);
        for (i = 0; i < 257; i++) src.push(16'(i));
        rdc(`ASFC_OFF_FSTAT, 24'h0007FF, 24'h000500);
        rdc(`ASFC_OFF_ISTAT, 24'hFFFFFF, 24'h000016);
        irq_is(1'b0);
        // Code 10 also streams, with no flush on the switch
        wr(`ASFC_OFF_CTRL, 24'h020000);
        src.push(16'd257);
        // Two oldest samples gone; drain down past the lower level
        for (i = 0; i < 193; i++)
            rdc(`ASFC_OFF_FDATA, 24'hFFFFFF, 24'(i + 2));
        rdc(`ASFC_OFF_ISTAT, 24'hFFFFFF, 24'h00001E);
        // Off flushes; a pop while off fails; samples go to DATA
        wr(`ASFC_OFF_CTRL, 24'h000000);
        rdc(`ASFC_OFF_FDATA, 24'hFFFFFF, 24'h000000);
        rdc(`ASFC_OFF_ISTAT, 24'hFFFFFF, 24'h00003F);
        src.push(16'h1234);
        rdc(`ASFC_OFF_DATA, 24'hFFFFFF, 24'h001234);
        // Fill mode, target 3 (code 1 deliberately avoided)
        wr(`ASFC_OFF_CTRL, 24'h010003);
        for (i = 0; i < 4; i++) src.push(16'(8'hA0 + i));
        rdc(`ASFC_OFF_FSTAT, 24'h0001FF, 24'h000003);
        rdc(`ASFC_OFF_ISTAT, 24'hFFFFFF, 24'h00007F);
        for (i = 0; i < 3; i++)
            rdc(`ASFC_OFF_FDATA, 24'hFFFFFF, 24'(8'hA0 + i));
        // Emptied by reading, so storing resumes
        src.push(16'h00B0);
        rdc(`ASFC_OFF_FDATA, 24'hFFFFFF, 24'h0000B0);
        // Each enable alone routes its set flag to the pin
        for (i = 0; i < 7; i++) begin
            wr(`ASFC_OFF_CTRL, 24'h010003 | (24'h000100 << i));
            irq_is(1'b1);
        end
        wr(`ASFC_OFF_CTRL, 24'h010003);
        irq_is(1'b0);
        // Clearing flags under full enables drops the pin at the end
        wr(`ASFC_OFF_CTRL, 24'h017F03);
        wr(`ASFC_OFF_ICLR, 24'h000001);
        rdc(`ASFC_OFF_ISTAT, 24'hFFFFFF, 24'h00007E);
        irq_is(1'b1);
        wr(`ASFC_OFF_ICLR, 24'h00007E);
        irq_is(1'b0);
        rdc(`ASFC_OFF_ICLR, 24'hFFFFFF, 24'h000000);
        // Fill mode, code zero: a whole 256 kept, then held
        wr(`ASFC_OFF_CTRL, 24'h010000);
        for (i = 0; i < 257; i++) src.push(16'(i + 1));
        rdc(`ASFC_OFF_FSTAT, 24'h000FFF, 24'h000D00);
        rdc(`ASFC_OFF_ISTAT, 24'hFFFFFF, 24'h000056);
        rdc(`ASFC_OFF_FDATA, 24'hFFFFFF, 24'h000001);
        // A read beside a conversion fails and leaves the head alone
        fork
            src.push(16'h7777);
            rdc(`ASFC_OFF_FDATA, 24'hFFFFFF, 24'h000002);
        join
        rdc(`ASFC_OFF_FDATA, 24'hFFFFFF, 24'h000002);
        rdc(`ASFC_OFF_ISTAT, 24'hFFFFFF, 24'h000076);
        stop_test();
    end
endmodule : tb
`default_nettype wire
